// ==== mask_store.sv ====
// small register store for the two mask registers with registered read data
`timescale 1ns/10ps
`include "sr_partial_array_refresh_regs.svh"
module mask_store #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,     // core clock
  input  wire logic             srst_i,    // sync reset, high
  input  wire logic             we_i,      // write strobe
  input  wire logic             sel_i,     // 0 bank, 1 segment
  input  wire logic [WIDTH-1:0] wdata_i,   // write data
  output logic      [WIDTH-1:0] bank_o,    // bank mask, registered
  output logic      [WIDTH-1:0] seg_o      // segment mask, registered
);
  initial begin
    if (WIDTH != 8) $error("mask_store: width must be 8");
  end
  // one word each; reset to all unmasked so a cold part refreshes everything
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      bank_o <= WIDTH'(`BANK_MASK_RST);
      seg_o  <= WIDTH'(`SEG_MASK_RST);
    end else if (we_i) begin
      if (sel_i) begin
        seg_o <= wdata_i;
      end else begin
        bank_o <= wdata_i;
      end
    end
  end
endmodule

// ==== self_refresh_partial_array.sv ====
// self refresh sequencing and partial-array refresh masking
`timescale 1ns/10ps
`include "sr_partial_array_refresh_regs.svh"
// Notes on behaviour
// - entry is CKE low, CS low, CA 0,0,1
// - self refresh held only while CKE low
// - internal timer refreshes; clock gated off
// - ignore all inputs except CKE
// - one all-bank refresh within minimum residency; code starts a 32 or 64 cycle sweep there, exit waits for it
// - exit delay from edge after CKE high
// - four or eight banks sized by density
// - 8-bit bank mask, one bit per bank
// - unmasked bank refreshes only unmasked segments
// - masked segment skipped, unmasked refreshed
// - segment bit spans all banks, masks combine
// - eight segments from 1Gb; none below
// - bit value 1 masked, 0 unmasked
module self_refresh_partial_array
  import sr_partial_array_refresh_pkg::*;
#(
  parameter int BANKS        = 4,
  parameter bit SEG_SUPPORT  = 1'b0,
  parameter int REFRESH_CYC  = `REFRESH_PERIOD_CYC
) (
  input  wire logic        clk_i,        // core clock, 25 MHz
  input  wire logic        srst_i,       // sync reset, high
  input  wire ca_bus_t     ca_i,         // sampled command/address
  output logic             in_self_o,    // device in self refresh
  output logic             clk_gate_o,   // internal clock gated off
  output logic             exit_busy_o,  // exit delay running
  output refresh_op_t      refresh_o,    // internal refresh strobe, registered
  output logic [7:0]       bank_mask_o,  // bank mask readback
  output logic [7:0]       seg_mask_o    // segment mask readback
);
  localparam int RES_CYC  = (`RESIDENCY_CYC < 1) ? 1 : `RESIDENCY_CYC;
  localparam int EXIT_CYC = (`EXIT_DELAY_CYC < 1) ? 1 : `EXIT_DELAY_CYC;
  localparam int SEGS     = 8;

  // only four or eight banks exist
  initial begin
    if (BANKS != 4 && BANKS != 8) $error("banks must be 4 or 8");
    if (BANKS == 4 && SEG_SUPPORT) $error("no segment masking below 1Gb");
    if (REFRESH_CYC < 1 || REFRESH_CYC > 255) $error("refresh period out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  function automatic logic is_entry(input ca_bus_t c);
    return !c.cke && !c.cs_n && c.ca_r[2:0] == 3'b100;
  endfunction

  function automatic logic region_on(input logic [7:0] bm, input logic [7:0] sm,
                                     input logic [2:0] b, input logic [2:0] s);
    logic seg_blk;
    seg_blk = SEG_SUPPORT ? sm[s] : 1'b0;
    return !bm[b] && !seg_blk;
  endfunction

  sr_state_t state_q;
  sr_state_t state_d;
  logic      mrw_we;
  logic      mrw_sel;

  // mask writes only accepted outside self refresh
  assign mrw_we  = (state_q == ST_ACTIVE) && ca_i.cke && ca_i.mode_register_write && !ca_i.cs_n &&
                   (ca_i.ma == `BANK_MASK_ADDR || ca_i.ma == `SEG_MASK_ADDR);
  assign mrw_sel = (ca_i.ma == `SEG_MASK_ADDR);

  mask_store #(
    .WIDTH (8)
  ) u_masks (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .we_i    (mrw_we),
    .sel_i   (mrw_sel),
    .wdata_i (ca_i.ca_f),
    .bank_o  (bank_mask_o),
    .seg_o   (seg_mask_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state machine

  logic [7:0] exit_cnt_q;
  logic       sweep_busy;
  logic       exit_done;

  assign exit_done = (exit_cnt_q == 8'(EXIT_CYC - 1)) && !sweep_busy;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_ACTIVE: begin
        if (is_entry(ca_i)) begin
          state_d = ST_ENTRY;
        end
      end
      ST_ENTRY: begin
        state_d = ca_i.cke ? ST_EXIT : ST_SELF;
      end
      // exit registered at first CKE high
      ST_SELF: begin
        if (ca_i.cke) begin
          state_d = ST_EXIT;
        end
      end
      // exit delay then back to active
      ST_EXIT: begin
        if (exit_done) begin
          state_d = ST_ACTIVE;
        end
      end
      default: state_d = ST_ACTIVE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= ST_ACTIVE;
    end else begin
      state_q <= state_d;
    end
  end

  // exit delay counter, saturates while refresh sweep drains
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      exit_cnt_q <= 8'h00;
    end else if (state_q != ST_EXIT) begin
      exit_cnt_q <= 8'h00;
    end else if (exit_cnt_q != 8'(EXIT_CYC - 1)) begin
      exit_cnt_q <= exit_cnt_q + 8'h01;
    end
  end

  assign in_self_o   = (state_q == ST_ENTRY) || (state_q == ST_SELF);
  assign clk_gate_o  = (state_q == ST_SELF);
  assign exit_busy_o = (state_q == ST_EXIT);

  ////////////////////////////////////////////////////////////////////////////
  // internal refresh timer and masked sweep

  logic [7:0] timer_q;
  logic [2:0] bank_q;
  logic [2:0] seg_q;
  logic       sweep_q;
  logic       first_q;

  assign sweep_busy = sweep_q;

  // first sweep starts at entry, then periodic; a sweep of 32 or 64 cycles outlasts residency
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      timer_q <= 8'h00;
      first_q <= 1'b0;
    end else if (state_q == ST_ENTRY) begin
      timer_q <= 8'h00;
      first_q <= 1'b1;
    end else if (state_q == ST_SELF) begin
      first_q <= 1'b0;
      timer_q <= (timer_q == 8'(REFRESH_CYC - 1)) ? 8'h00 : timer_q + 8'h01;
    end else begin
      first_q <= 1'b0;
      timer_q <= 8'h00;
    end
  end

  // a sweep in progress keeps going through the exit delay
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sweep_q <= 1'b0;
      bank_q  <= 3'h0;
      seg_q   <= 3'h0;
    end else if (!sweep_q) begin
      if (first_q || (state_q == ST_SELF && timer_q == 8'(REFRESH_CYC - 1))) begin
        sweep_q <= 1'b1;
        bank_q  <= 3'h0;
        seg_q   <= 3'h0;
      end
    end else if (seg_q == 3'(SEGS - 1)) begin
      seg_q <= 3'h0;
      if (bank_q == 3'(BANKS - 1)) begin
        sweep_q <= 1'b0;
        bank_q  <= 3'h0;
      end else begin
        bank_q <= bank_q + 3'h1;
      end
    end else begin
      seg_q <= seg_q + 3'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      refresh_o <= '0;
    end else begin
      refresh_o.valid <= sweep_q && region_on(bank_mask_o, seg_mask_o, bank_q, seg_q);
      refresh_o.bank  <= bank_q;
      refresh_o.seg   <= seg_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // exit length counted apart from exit_cnt_q, so a broken counter still shows
  logic [7:0] exit_len_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      exit_len_q <= 8'h00;
    end else if (!exit_busy_o) begin
      exit_len_q <= 8'h00;
    end else if (exit_len_q != 8'hff) begin
      exit_len_q <= exit_len_q + 8'h01;
    end
  end

  // entry decoded leads to self refresh
  a_entry_decode: assert property (@(posedge clk_i) disable iff (srst_i)
    state_q == ST_ACTIVE && is_entry(ca_i) |=> in_self_o)
    else $error("entry pattern not taken");

  // CKE high while resident leaves self refresh
  a_cke_exit: assert property (@(posedge clk_i) disable iff (srst_i)
    state_q == ST_SELF && ca_i.cke |=> exit_busy_o)
    else $error("exit not registered on cke high");

  a_clk_gated: assert property (@(posedge clk_i) disable iff (srst_i)
    in_self_o && !ca_i.cke |=> clk_gate_o && in_self_o)
    else $error("clock not gated in self refresh");

  // internal sweep only while resident or exiting
  a_idle_sweep: assert property (@(posedge clk_i) disable iff (srst_i)
    state_q == ST_ACTIVE |-> !sweep_q)
    else $error("sweep running while active");

  // no mask change while in self refresh (entry or resident)
  a_mask_frozen: assert property (@(posedge clk_i) disable iff (srst_i)
    in_self_o |=> $stable(bank_mask_o) && $stable(seg_mask_o))
    else $error("mask changed in self refresh");

  // sweep starts within three cycles of the entry command
  a_first_sweep: assert property (@(posedge clk_i) disable iff (srst_i)
    state_q == ST_ACTIVE && is_entry(ca_i) |-> ##[1:3] sweep_q)
    else $error("no refresh after entry");

  a_resid_refresh: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(clk_gate_o) |-> ##[0:RES_CYC] sweep_q)
    else $error("no refresh within residency");

  // exit delay lasts at least its count
  a_exit_min: assert property (@(posedge clk_i) disable iff (srst_i)
    $fell(exit_busy_o) |-> exit_len_q >= 8'(EXIT_CYC))
    else $error("exit delay cut short");

  a_bank_write: assert property (@(posedge clk_i) disable iff (srst_i)
    state_q == ST_ACTIVE && ca_i.cke && !ca_i.cs_n && ca_i.mode_register_write &&
    ca_i.ma == `BANK_MASK_ADDR |=> bank_mask_o == $past(ca_i.ca_f))
    else $error("bank mask write lost");

  a_seg_write: assert property (@(posedge clk_i) disable iff (srst_i)
    state_q == ST_ACTIVE && ca_i.cke && !ca_i.cs_n && ca_i.mode_register_write &&
    ca_i.ma == `SEG_MASK_ADDR |=> seg_mask_o == $past(ca_i.ca_f))
    else $error("segment mask write lost");

  // sweep steps one segment per cycle
  a_sweep_step: assert property (@(posedge clk_i) disable iff (srst_i)
    sweep_q && seg_q != 3'(SEGS - 1) |=> seg_q == $past(seg_q) + 3'h1)
    else $error("segment step skipped");

  a_region_on: assert property (@(posedge clk_i) disable iff (srst_i)
    sweep_q && !bank_mask_o[bank_q] && !(SEG_SUPPORT && seg_mask_o[seg_q])
    |=> refresh_o.valid)
    else $error("unmasked region skipped");

  a_bank_blocked: assert property (@(posedge clk_i) disable iff (srst_i)
    refresh_o.valid |-> !bank_mask_o[refresh_o.bank])
    else $error("masked bank refreshed");

  // segment mask blocks only when supported
  a_seg_blocked: assert property (@(posedge clk_i) disable iff (srst_i)
    refresh_o.valid && SEG_SUPPORT |-> !seg_mask_o[refresh_o.seg])
    else $error("masked segment refreshed");

  // exit with no sweep running ends within EXIT_CYC cycles
  a_exit_drain: assert property (@(posedge clk_i) disable iff (srst_i)
    exit_busy_o && !$past(sweep_q) |-> ##[0:EXIT_CYC] !exit_busy_o || sweep_q)
    else $error("exit delay overran");
endmodule

// ==== sr_ctrl_model.sv ====
// controller model driving the command/address bus of the self refresh block
`timescale 1ns/10ps
module sr_ctrl_model
  import sr_partial_array_refresh_pkg::*;
(
  input  wire logic clk_i, // core clock
  output ca_bus_t   ca_o   // command/address to device
);
  logic [7:0] junk_q = 8'h00;
  ////////////////////////////////////////////////////////////
  // deselected at time zero so reset sees no command
  initial ca_o = '{1'b1, 1'b1, 4'h3, 8'h00, 8'h00, 1'b0};
  // changes land at the falling edge and hold a full cycle
  task automatic cmd(input logic cke, input logic [3:0] car, input logic [7:0] ma,
                     input logic [7:0] d, input logic w);
    @(negedge clk_i);
    ca_o = '{cke, 1'b0, car, d, ma, w};
  endtask
  task automatic nop();
    cmd(1'b1, 4'h3, 8'h00, 8'h00, 1'b0);
  endtask
  task automatic mode_register_write(input logic [7:0] a, input logic [7:0] d);
    cmd(1'b1, 4'h0, a, d, 1'b1);
  endtask
  task automatic all_bank_refresh();
    cmd(1'b1, 4'h4, 8'h00, 8'h00, 1'b0);
  endtask
  // idle banks, cke high, nop after
  task automatic enter();
    nop();
    cmd(1'b0, 4'h4, 8'h00, 8'h00, 1'b0);
    cmd(1'b0, 4'h3, 8'h00, 8'h00, 1'b0);
  endtask
  task automatic hold();
    junk_q = junk_q + 8'h01;
    cmd(1'b0, junk_q[3:0], 8'h10, ~junk_q, 1'b1);
  endtask
  task automatic wake();
    repeat (2) cmd(1'b0, 4'h3, 8'h00, 8'h00, 1'b0);
    nop();
  endtask
endmodule

// ==== sr_partial_array_refresh_pkg.sv ====
// types shared by the self refresh and masking block
package sr_partial_array_refresh_pkg;
  typedef enum logic [3:0] {
    ST_ACTIVE = 4'b0001,
    ST_ENTRY  = 4'b0010,
    ST_SELF   = 4'b0100,
    ST_EXIT   = 4'b1000
  } sr_state_t;
  typedef struct packed {
    logic       cke;
    logic       cs_n;
    logic [3:0] ca_r;
    logic [7:0] ca_f;
    logic [7:0] ma;
    logic       mode_register_write;
  } ca_bus_t;
  typedef struct packed {
    logic       valid;
    logic [2:0] bank;
    logic [2:0] seg;
  } refresh_op_t;
endpackage

// ==== sr_partial_array_refresh_regs.svh ====
// register offsets, reset values and timing counts for self refresh / masking
`ifndef SR_PARTIAL_ARRAY_REFRESH_REGS_SVH
`define SR_PARTIAL_ARRAY_REFRESH_REGS_SVH
`define BANK_MASK_ADDR     8'h10
`define SEG_MASK_ADDR      8'h11
`define BANK_MASK_RST      8'h00
`define SEG_MASK_RST       8'h00
`define CLK_PERIOD_NS      40
`define RESIDENCY_NS       15
`define RESIDENCY_CYC      ((`RESIDENCY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EXIT_DELAY_NS      140
`define EXIT_DELAY_CYC     ((`EXIT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REFRESH_PERIOD_CYC 16
`define ROW_STEPS          8
`endif

// ==== testbench.sv ====
// self-checking bench: mask writes, self refresh sweeps and exit timing
`timescale 1ns/10ps
`include "sr_partial_array_refresh_regs.svh"
module testbench
  import sr_partial_array_refresh_pkg::*;
;
  logic        clk_i  = 1'b0;
  logic        srst_i = 1'b1;
  ca_bus_t     ca;
  logic        in_self, clk_gate, exit_busy;
  refresh_op_t refresh;
  logic [7:0]  bank_mask, seg_mask;
  logic [63:0] hits;
  int          mismatches = 0, compares = 0, cycles = 0;
  ////////////////////////////////////////////////////////////
  // eight banks with segments, a 1Gb-class part
  sr_ctrl_model u_sr_ctrl_model (.clk_i(clk_i), .ca_o(ca));
  self_refresh_partial_array #(.BANKS(8), .SEG_SUPPORT(1'b1),
    .REFRESH_CYC(`REFRESH_PERIOD_CYC)) u_self_refresh_partial_array (
    .clk_i(clk_i), .srst_i(srst_i), .ca_i(ca), .in_self_o(in_self),
    .clk_gate_o(clk_gate), .exit_busy_o(exit_busy), .refresh_o(refresh),
    .bank_mask_o(bank_mask), .seg_mask_o(seg_mask));
  always #20 clk_i = ~clk_i;
  // region map of internal refreshes, bank major
  always @(posedge clk_i) begin
    if (refresh.valid === 1'b1) hits[{refresh.bank, refresh.seg}] <= 1'b1;
  end
  // hang guard, a test takes about 200 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one program, one residency, one exit
  task automatic sr_test(input logic [7:0] bm, input logic [7:0] sm);
    logic [63:0] exp;
    int          bad, busy;
    bad = 0;
    busy = 0;
    for (int b = 0; b < 8; b++) for (int s = 0; s < 8; s++) exp[b*8+s] = !bm[b] && !sm[s];
    u_sr_ctrl_model.mode_register_write(`BANK_MASK_ADDR, bm);
    u_sr_ctrl_model.mode_register_write(`SEG_MASK_ADDR, sm);
    repeat (2) u_sr_ctrl_model.nop();
    check("bank_mask", {56'h0, bank_mask}, {56'h0, bm});
    check("seg_mask", {56'h0, seg_mask}, {56'h0, sm});
    hits = '0;
    u_sr_ctrl_model.enter();
    u_sr_ctrl_model.hold();
    check("in_self", {63'h0, in_self}, 64'h1);
    u_sr_ctrl_model.hold();
    repeat (100) begin
      u_sr_ctrl_model.hold();
      if (in_self !== 1'b1 || clk_gate !== 1'b1) bad++;
    end
    check("held", bad, 0);
    u_sr_ctrl_model.wake();
    // nops with cke high all through exit
    repeat (80) begin
      u_sr_ctrl_model.nop();
      if (exit_busy === 1'b1) busy++;
    end
    check("exit_long", {63'h0, busy >= `EXIT_DELAY_CYC}, 64'h1);
    // a full 64-region sweep may stretch exit, never more
    check("exit_bound", {63'h0, busy <= `EXIT_DELAY_CYC + 64}, 64'h1);
    check("exit_done", {62'h0, exit_busy, in_self}, 64'h0);
    check("regions", hits, exp);
    check("masks_kept", {48'h0, bank_mask, seg_mask}, {48'h0, bm, sm});
    u_sr_ctrl_model.all_bank_refresh();
    $display("test masks %h %h done", bm, sm);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    srst_i = 1'b0;
    u_sr_ctrl_model.nop();
    check("reset_masks", {48'h0, bank_mask, seg_mask}, 64'h0);
    // wrong pattern with cke low: CA0 high
    u_sr_ctrl_model.cmd(1'b0, 4'h5, 8'h00, 8'h00, 1'b0);
    repeat (2) u_sr_ctrl_model.nop();
    check("no_entry", {63'h0, in_self}, 64'h0);
    $display("test refusal done");
    sr_test(8'h0A, 8'h84);
    sr_test(8'h00, 8'h00);
    sr_test(8'hFF, 8'h00);
    sr_test(8'h81, 8'h7E);
    tally_and_finish();
  end
endmodule
